// >>> sfr_seq.sv
// Power-up, reset and protocol-recovery sequencer of a serial NOR flash
//
// Notes on behaviour
// - Below power-on threshold, everything but the link capture and command code report held in reset.
// - Power-up phase accepts only the two status reads.
// - After power-up: standby, no latch, unlocked.
// - Controller flag reads 0 while busy, 1 after.
// - Full recovery gives extended protocol, direct read off.
// - Hardware reset ready in 40 ns or 30 us.
// - Reset during slow register writes waits the write.
// - Software reset ready in 90 ns or 30 us.
// - A frame with every clock all-ones on both data lines ends direct read mode.
`timescale 1ns/100ps
`default_nettype none
module sfr_seq #(
  parameter int unsigned PWR_FULL_CYC = sfr_pkg::PWR_FULL_CYC,
  parameter int unsigned PWR_POLL_CYC = sfr_pkg::PWR_POLL_CYC,
  parameter int unsigned PROG_CYC     = 2000,
  parameter int unsigned SR_WR_CYC    = 4000,
  parameter int unsigned NVCR_WR_CYC  = 4000,
  parameter int unsigned SSE_CYC      = 8000
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       serial_data_line0_i,
  input  wire logic       hold_data_line3_i,
  input  wire logic       supply_ok_i,
  input  wire logic       hw_reset_n_i,
  input  wire logic       nv_direct_read_i,
  input  wire logic [1:0] nv_proto_i,
  output logic            ready_o,
  output logic            standby_o,
  output logic            deep_pd_o,
  output logic            wel_o,
  output logic            wip_o,
  output logic            pec_flag_o,
  output logic            write_lock_o,
  output logic            lock_down_o,
  output logic            direct_read_mode_o,
  output logic [1:0]      proto_o,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_code_o,
  output logic            cmd_ignored_o
);

  localparam int TW = sfr_pkg::TMR_W;
  localparam logic [TW-1:0] HW_FAST = TW'(sfr_pkg::HW_FAST_CYC - 1);
  localparam logic [TW-1:0] HW_SLOW = TW'(sfr_pkg::HW_SLOW_CYC - 1);
  localparam logic [TW-1:0] SW_FAST = TW'(sfr_pkg::SW_FAST_CYC - 1);
  localparam logic [TW-1:0] SW_SLOW = TW'(sfr_pkg::SW_SLOW_CYC - 1);
  localparam logic [TW-1:0] PWR_END = TW'(PWR_FULL_CYC - 1);
  localparam logic [TW-1:0] PWR_POLL = TW'(PWR_POLL_CYC);

  function automatic logic [TW-1:0] op_dur(input sfr_pkg::sfr_opk_t k);
    case (k)
      sfr_pkg::OPK_SR:   return TW'(SR_WR_CYC);
      sfr_pkg::OPK_NVCR: return TW'(NVCR_WR_CYC);
      sfr_pkg::OPK_SSE:  return TW'(SSE_CYC);
      default:           return TW'(PROG_CYC);
    endcase
  endfunction

  sfr_frame_if frm ();

  sfr_link_cap u_link (
    .rst_n_i (rst_n_i),
    .sck_i   (sck_i),
    .cs_n_i  (cs_n_i),
    .dq0_i   (serial_data_line0_i),
    .dq3_i   (hold_data_line3_i),
    .frm     (frm)
  );

  logic                sup_s1, sup_s2, hwr_s1, hwr_s2, cs_s1, cs_s2, cs_s3;
  sfr_pkg::sfr_state_t state_r;
  sfr_pkg::sfr_opk_t   opk_r;
  logic [TW-1:0]       pwr_cnt_r, rec_cnt_r, op_tmr_r;
  logic                busy_r, wel_r, wlock_r, ldown_r, dr_r, rst_en_r;
  logic [1:0]          proto_r;
  logic [2:0]          rec_idx_r;
  logic                cmd_valid_r, cmd_ign_r;
  logic [7:0]          cmd_code_r;

  // Pins and the chip select cross into the core clock through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {sup_s1, sup_s2} <= 2'h0;
      {hwr_s1, hwr_s2} <= 2'h3;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
    end else begin
      {sup_s1, sup_s2} <= {supply_ok_i, sup_s1};
      {hwr_s1, hwr_s2} <= {hw_reset_n_i, hwr_s1};
      {cs_s1, cs_s2, cs_s3} <= {cs_n_i, cs_s1, cs_s2};
    end
  end

  // Frame fields are frozen while deselected, so they are read directly at frame end
  logic       frame_end, has_cmd, is_stat, live, acc, sw_rst, start_op, op_done;
  logic [7:0] op;
  assign frame_end = cs_s2 & ~cs_s3;
  assign op        = frm.cmd;
  assign has_cmd   = frm.clk_cnt >= sfr_pkg::CMD_BITS;
  assign is_stat   = (op == sfr_pkg::OP_RD_STATUS) || (op == sfr_pkg::OP_RD_FLAG);
  assign live      = frame_end && has_cmd && sup_s2 && hwr_s2 && !dr_r && proto_r == sfr_pkg::PROTO_EXT;
  assign op_done   = busy_r && op_tmr_r == '0;

  always_comb begin
    acc = 1'b0;
    if (live) begin
      case (state_r)
        sfr_pkg::ST_PWRUP: begin
          acc = is_stat && pwr_cnt_r >= PWR_POLL;
        end
        sfr_pkg::ST_STANDBY: begin
          acc = is_stat || op == sfr_pkg::OP_WR_EN || op == sfr_pkg::OP_WR_DIS
             || op == sfr_pkg::OP_DPD || op == sfr_pkg::OP_RST_EN
             || (op == sfr_pkg::OP_RST_MEM && rst_en_r)
             || (wel_r && (op == sfr_pkg::OP_WR_LOCK || sfr_pkg::op_kind(op) != sfr_pkg::OPK_NONE));
        end
        sfr_pkg::ST_BUSY: begin
          acc = is_stat || op == sfr_pkg::OP_RST_EN || (op == sfr_pkg::OP_RST_MEM && rst_en_r);
        end
        sfr_pkg::ST_DPD: begin
          acc = op == sfr_pkg::OP_DPD_REL || op == sfr_pkg::OP_RST_EN || (op == sfr_pkg::OP_RST_MEM && rst_en_r);
        end
        default: begin
          acc = 1'b0;
        end
      endcase
    end
  end

  assign sw_rst   = acc && op == sfr_pkg::OP_RST_MEM;
  assign start_op = acc && state_r == sfr_pkg::ST_STANDBY && sfr_pkg::op_kind(op) != sfr_pkg::OPK_NONE;

  // Main sequence: power-up hold-off, standby, busy, deep power-down, reset recovery
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= sfr_pkg::ST_OFF;
      pwr_cnt_r <= '0;
      rec_cnt_r <= '0;
    end else if (!sup_s2) begin
      state_r   <= sfr_pkg::ST_OFF;
      pwr_cnt_r <= '0;
      rec_cnt_r <= '0;
    end else if (state_r == sfr_pkg::ST_OFF) begin
      state_r <= sfr_pkg::ST_PWRUP;
    end else if (state_r == sfr_pkg::ST_PWRUP) begin
      pwr_cnt_r <= pwr_cnt_r + 1'b1;
      if (pwr_cnt_r >= PWR_END) begin
        state_r <= sfr_pkg::ST_STANDBY;
      end
    end else if (!hwr_s2) begin
      // Recovery length is chosen from the state the reset interrupted
      state_r <= sfr_pkg::ST_RECOVER;
      if (state_r != sfr_pkg::ST_RECOVER) begin
        rec_cnt_r <= (state_r == sfr_pkg::ST_DPD || (busy_r && opk_r == sfr_pkg::OPK_ARRAY)) ? HW_SLOW : HW_FAST;
      end
    end else if (sw_rst) begin
      state_r   <= sfr_pkg::ST_RECOVER;
      rec_cnt_r <= (state_r == sfr_pkg::ST_DPD || (busy_r && opk_r == sfr_pkg::OPK_ARRAY)) ? SW_SLOW : SW_FAST;
    end else begin
      case (state_r)
        sfr_pkg::ST_STANDBY: begin
          if (start_op) begin
            state_r <= sfr_pkg::ST_BUSY;
          end else if (acc && op == sfr_pkg::OP_DPD) begin
            state_r <= sfr_pkg::ST_DPD;
          end
        end
        sfr_pkg::ST_BUSY: begin
          if (!busy_r) begin
            state_r <= sfr_pkg::ST_STANDBY;
          end
        end
        sfr_pkg::ST_DPD: begin
          if (acc && op == sfr_pkg::OP_DPD_REL) begin
            state_r <= sfr_pkg::ST_STANDBY;
          end
        end
        sfr_pkg::ST_RECOVER: begin
          if (rec_cnt_r != '0) begin
            rec_cnt_r <= rec_cnt_r - 1'b1;
          end else if (!busy_r) begin
            state_r <= sfr_pkg::ST_STANDBY;
          end
        end
        default: begin
          state_r <= sfr_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Program and erase timer; slow register writes and erase survive a reset, array ops abort on hardware reset only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r   <= 1'b0;
      opk_r    <= sfr_pkg::OPK_NONE;
      op_tmr_r <= '0;
    end else if (!sup_s2) begin
      busy_r   <= 1'b0;
      opk_r    <= sfr_pkg::OPK_NONE;
      op_tmr_r <= '0;
    end else if (start_op) begin
      busy_r   <= 1'b1;
      opk_r    <= sfr_pkg::op_kind(op);
      op_tmr_r <= op_dur(sfr_pkg::op_kind(op));
    end else if (busy_r) begin
      if ((!hwr_s2 && opk_r == sfr_pkg::OPK_ARRAY) || op_done) begin
        busy_r <= 1'b0;
        opk_r  <= sfr_pkg::OPK_NONE;
      end else begin
        op_tmr_r <= op_tmr_r - 1'b1;
      end
    end
  end

  // Volatile status, lock and protocol state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wel_r     <= 1'b0;
      wlock_r   <= 1'b0;
      ldown_r   <= 1'b0;
      rst_en_r  <= 1'b0;
      dr_r      <= 1'b0;
      proto_r   <= sfr_pkg::PROTO_EXT;
      rec_idx_r <= '0;
    end else if (!sup_s2 || state_r == sfr_pkg::ST_OFF || state_r == sfr_pkg::ST_PWRUP
                 || !hwr_s2 || sw_rst) begin
      wel_r     <= 1'b0;
      wlock_r   <= 1'b0;
      ldown_r   <= 1'b0;
      rst_en_r  <= 1'b0;
      dr_r      <= nv_direct_read_i;
      proto_r   <= nv_proto_i;
      rec_idx_r <= '0;
    end else begin
      if (frame_end && frm.all_ones) begin
        if (rec_idx_r == sfr_pkg::REC_STEPS && frm.clk_cnt == sfr_pkg::FIN_LEN) begin
          proto_r   <= sfr_pkg::PROTO_EXT;
          dr_r      <= 1'b0;
          rec_idx_r <= '0;
        end else begin
          if (dr_r) begin
            dr_r <= 1'b0;
          end
          if (rec_idx_r != sfr_pkg::REC_STEPS && frm.clk_cnt == sfr_pkg::burst_len(rec_idx_r)) begin
            rec_idx_r <= rec_idx_r + 3'h1;
          end else begin
            rec_idx_r <= (frm.clk_cnt == sfr_pkg::burst_len(3'h0)) ? 3'h1 : 3'h0;
          end
        end
      end else if (frame_end) begin
        rec_idx_r <= '0;
      end
      if (acc && op == sfr_pkg::OP_WR_EN) begin
        wel_r <= 1'b1;
      end else if ((acc && (op == sfr_pkg::OP_WR_DIS || op == sfr_pkg::OP_WR_LOCK)) || op_done) begin
        wel_r <= 1'b0;
      end
      if (acc && op == sfr_pkg::OP_WR_LOCK && frm.clk_cnt >= sfr_pkg::DAT_BITS) begin
        ldown_r <= ldown_r | frm.dat[1];
        wlock_r <= ldown_r ? wlock_r : frm.dat[0];
      end
      if (frame_end && has_cmd) begin
        rst_en_r <= acc && op == sfr_pkg::OP_RST_EN;
      end
    end
  end

  // Per-frame command report
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_r <= 1'b0;
      cmd_ign_r   <= 1'b0;
      cmd_code_r  <= '0;
    end else begin
      cmd_valid_r <= acc;
      // Below the supply threshold or before power-up starts, frames get no answer at all
      cmd_ign_r   <= frame_end && has_cmd && sup_s2 && state_r != sfr_pkg::ST_OFF && !acc;
      if (frame_end && has_cmd) begin
        cmd_code_r <= op;
      end
    end
  end

  assign ready_o            = state_r == sfr_pkg::ST_STANDBY || state_r == sfr_pkg::ST_BUSY || state_r == sfr_pkg::ST_DPD;
  assign standby_o          = state_r == sfr_pkg::ST_STANDBY;
  assign deep_pd_o          = state_r == sfr_pkg::ST_DPD;
  assign wel_o              = wel_r;
  assign wip_o              = busy_r;
  assign pec_flag_o         = ~busy_r;
  assign write_lock_o       = wlock_r;
  assign lock_down_o        = ldown_r;
  assign direct_read_mode_o = dr_r;
  assign proto_o            = proto_r;
  assign cmd_valid_o        = cmd_valid_r;
  assign cmd_ignored_o      = cmd_ign_r;
  assign cmd_code_o         = cmd_code_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  localparam int A_HW_MAX = 8;
  localparam int A_SW_MAX = 13;

  sequence s_part_one_done;
    rec_idx_r == sfr_pkg::REC_STEPS && sup_s2 && hwr_s2;
  endsequence
  sequence s_final_burst;
    frame_end && frm.all_ones && frm.clk_cnt == sfr_pkg::FIN_LEN;
  endsequence

  a_por_hold: assert property (!sup_s2 |=> state_r == sfr_pkg::ST_OFF && !ready_o && !cmd_valid_o)
    else $error("logic not held in reset below supply threshold");
  a_pwrup_only_status: assert property ((state_r == sfr_pkg::ST_PWRUP && frame_end && has_cmd && !is_stat)
    |=> !cmd_valid_o && cmd_ignored_o)
    else $error("non-status command taken during power-up");
  a_pwrup_clean_state: assert property (state_r == sfr_pkg::ST_PWRUP ##1 state_r == sfr_pkg::ST_STANDBY
    |-> !wel_o && !wip_o && !write_lock_o && !lock_down_o)
    else $error("state after power-up not clean");
  a_pec_flag_op: assert property ((start_op && sup_s2 && hwr_s2) |=> !pec_flag_o ##0 wip_o)
    else $error("controller flag not low during operation");
  a_pec_flag_done: assert property ((op_done && sup_s2) |=> pec_flag_o && !wip_o)
    else $error("controller flag not set at completion");
  a_recovery_exit: assert property (s_part_one_done ##0 s_final_burst
    |=> proto_o == sfr_pkg::PROTO_EXT && !direct_read_mode_o)
    else $error("recovery did not restore extended protocol");
  a_hw_fast_ready: assert property (($rose(hwr_s2) && sup_s2 && rec_cnt_r == HW_FAST && !busy_r)
    |-> ##[1:A_HW_MAX] ready_o)
    else $error("hardware reset recovery too slow");
  a_hw_slow_hold: assert property (($rose(hwr_s2) && sup_s2 && rec_cnt_r == HW_SLOW)
    |-> ##A_HW_MAX !ready_o)
    else $error("slow hardware reset recovery ended early");
  a_rst_waits_write: assert property ((!hwr_s2 && busy_r && opk_r != sfr_pkg::OPK_ARRAY && op_tmr_r > 1)
    |=> busy_r && !ready_o)
    else $error("reset cut a slow register write short");
  a_sw_fast_ready: assert property ((sw_rst && state_r == sfr_pkg::ST_STANDBY && !busy_r)
    |=> !ready_o ##[1:A_SW_MAX] ready_o)
    else $error("software reset recovery too slow");
  a_direct_read_exit: assert property ((frame_end && frm.all_ones && dr_r && sup_s2 && hwr_s2 && !sw_rst)
    |=> !direct_read_mode_o)
    else $error("all-ones frame did not end direct read");

endmodule
`default_nettype wire

// >>> sfr_pkg.sv
// Shared constants, timing counts and types of the flash power, reset and recovery sequencer
package sfr_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // Longest times round down, never below one cycle
  function automatic int cyc_dn(input int ns);
    return (ns < CLK_PERIOD_NS) ? 1 : ns / CLK_PERIOD_NS;
  endfunction

  localparam int POWER_TO_READ_DELAY_US        = 150;
  localparam int POWER_TO_FULL_ACCESS_DELAY_US = 150;
  localparam int POWER_TO_POLLING_DELAY_US     = 100;
  localparam int RESET_PULSE_WIDTH_NS          = 50;
  localparam int RECOVERY_DESELECT_MIN_TIME_NS = 50;
  localparam int HW_RESET_RECOVERY_FAST_NS     = 40;
  localparam int HW_RESET_RECOVERY_SLOW_US     = 30;
  localparam int SW_RESET_RECOVERY_FAST_NS     = 90;
  localparam int SW_RESET_RECOVERY_SLOW_US     = 30;

  localparam int PWR_FULL_CYC = cyc_dn(POWER_TO_FULL_ACCESS_DELAY_US * 1000);
  localparam int PWR_POLL_CYC = cyc_dn(POWER_TO_POLLING_DELAY_US * 1000);
  localparam int HW_FAST_CYC  = cyc_dn(HW_RESET_RECOVERY_FAST_NS);
  localparam int HW_SLOW_CYC  = cyc_dn(HW_RESET_RECOVERY_SLOW_US * 1000);
  localparam int SW_FAST_CYC  = cyc_dn(SW_RESET_RECOVERY_FAST_NS);
  localparam int SW_SLOW_CYC  = cyc_dn(SW_RESET_RECOVERY_SLOW_US * 1000);

  localparam int TMR_W = 24;
  localparam int CNT_W = 6;

  localparam logic [CNT_W-1:0] CNT_MAX   = 6'h3f;
  localparam logic [CNT_W-1:0] CMD_BITS  = 6'h08;
  localparam logic [CNT_W-1:0] DAT_BITS  = 6'h10;
  localparam logic [CNT_W-1:0] FIN_LEN   = 6'h08;
  localparam logic [2:0]       REC_STEPS = 3'h6;

  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_RD_FLAG   = 8'h70;
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_SSE       = 8'h20;
  localparam logic [7:0] OP_WR_STAT   = 8'h01;
  localparam logic [7:0] OP_WR_NVCR   = 8'hb1;
  localparam logic [7:0] OP_WR_LOCK   = 8'he5;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST_MEM   = 8'h99;
  localparam logic [7:0] OP_DPD       = 8'hb9;
  localparam logic [7:0] OP_DPD_REL   = 8'hab;

  localparam logic [1:0] PROTO_EXT = 2'h0;

  typedef enum logic [2:0] {ST_OFF, ST_PWRUP, ST_STANDBY, ST_BUSY, ST_DPD, ST_RECOVER} sfr_state_t;
  typedef enum logic [2:0] {OPK_NONE, OPK_ARRAY, OPK_SR, OPK_NVCR, OPK_SSE} sfr_opk_t;

  function automatic logic [CNT_W-1:0] burst_len(input logic [2:0] idx);
    case (idx)
      3'h0:    return 6'h07;
      3'h1:    return 6'h09;
      3'h2:    return 6'h0d;
      3'h3:    return 6'h11;
      3'h4:    return 6'h19;
      default: return 6'h21;
    endcase
  endfunction

  function automatic sfr_opk_t op_kind(input logic [7:0] op);
    case (op)
      OP_PROG:    return OPK_ARRAY;
      OP_WR_STAT: return OPK_SR;
      OP_WR_NVCR: return OPK_NVCR;
      OP_SSE:     return OPK_SSE;
      default:    return OPK_NONE;
    endcase
  endfunction

endpackage

// >>> sfr_frame_if.sv
// Frame summary carried from the link-clock capture to the sequencer core
`timescale 1ns/100ps
`default_nettype none
interface sfr_frame_if;
  logic [5:0] clk_cnt;
  logic       all_ones;
  logic [7:0] cmd;
  logic [7:0] dat;
  modport link (output clk_cnt, output all_ones, output cmd, output dat);
  modport core (input clk_cnt, input all_ones, input cmd, input dat);
endinterface
`default_nettype wire

// >>> sfr_link_cap.sv
// Link-clock capture of one chip-select frame: clock count, all-ones flag, command and data byte
`timescale 1ns/100ps
`default_nettype none
module sfr_link_cap (
  input  wire logic   rst_n_i,
  input  wire logic   sck_i,
  input  wire logic   cs_n_i,
  input  wire logic   dq0_i,
  input  wire logic   dq3_i,
  sfr_frame_if.link   frm
);

  logic                     in_frame_r;
  logic [sfr_pkg::CNT_W-1:0] cnt_r;
  logic                     ones_r;
  logic [6:0]               sh_r;
  logic [7:0]               cmd_r;
  logic [7:0]               dat_r;

  // Deselect ends the frame without needing another link clock edge
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  // Results stay frozen while deselected so the core can read them
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      ones_r <= 1'b0;
      sh_r   <= '0;
    end else if (!in_frame_r) begin
      cnt_r  <= 6'h01;
      ones_r <= dq0_i & dq3_i;
      sh_r   <= {6'h00, dq0_i};
    end else begin
      if (cnt_r != sfr_pkg::CNT_MAX) begin
        cnt_r <= cnt_r + 6'h01;
      end
      ones_r <= ones_r & dq0_i & dq3_i;
      sh_r   <= {sh_r[5:0], dq0_i};
    end
  end

  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_r <= '0;
      dat_r <= '0;
    end else if (in_frame_r && cnt_r == sfr_pkg::CMD_BITS - 6'h01) begin
      cmd_r <= {sh_r, dq0_i};
    end else if (in_frame_r && cnt_r == sfr_pkg::DAT_BITS - 6'h01) begin
      dat_r <= {sh_r, dq0_i};
    end
  end

  assign frm.clk_cnt  = cnt_r;
  assign frm.all_ones = ones_r;
  assign frm.cmd      = cmd_r;
  assign frm.dat      = dat_r;

endmodule
`default_nettype wire

// >>> sfr_host_model.sv
// Host controller model: chip-select frames with link clock and data lines
`timescale 1ns/100ps
`default_nettype none
module sfr_host_model (
  output var logic sck_o,
  output var logic cs_n_o,
  output var logic dq0_o,
  output var logic dq3_o
);
  localparam int HALF_NS = 80;
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    dq0_o  = 1'b0;
    dq3_o  = 1'b1;
  end
  // Frame of n clocks, v sent MSB first, ones past bit 16
  task automatic frame(input int n, input logic [15:0] v);
    #3;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      dq0_o = (i < 16) ? v[15-i] : 1'b1;
      dq3_o = 1'b1;
      #HALF_NS sck_o = 1'b1;
      #HALF_NS sck_o = 1'b0;
    end
    #20 cs_n_o = 1'b1;
    // Released lines must not keep their last value
    dq0_o = ~dq0_o;
    dq3_o = ~dq3_o;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> tb_serial_flash_power_reset_recovery.sv
// Testbench of the flash power, reset and recovery sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_serial_flash_power_reset_recovery;
  localparam int PFULL = 1200;
  localparam int PPOLL = 300;
  localparam int PROG  = 600;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       supply_ok_i = 1'b0;
  logic       hw_reset_n_i = 1'b1;
  logic       nv_direct_read_i = 1'b0;
  logic [1:0] nv_proto_i = 2'h0;
  logic       sck, cs_n, dq0, dq3;
  logic       ready_o, standby_o, wel_o, wip_o, pec_flag_o, write_lock_o, lock_down_o;
  logic       direct_read_mode_o, cmd_valid_o, cmd_ignored_o, rdy_q;
  logic [1:0] proto_o;
  int         errors = 0, check_count = 0, nvalid = 0, nign = 0, exp_valid = 0, exp_ign = 0;
  int         cyc = 0, t_fall = 0, t_rise = 0, t0, n;
  int         rec_q[$] = '{7, 9, 13, 17, 25, 33};
  logic [7:0] op;
  logic [7:0] cmd_code;

  always #4 clk_i = ~clk_i;

  sfr_host_model sfr_host_model_i (.sck_o(sck), .cs_n_o(cs_n), .dq0_o(dq0), .dq3_o(dq3));

  sfr_seq #(.PWR_FULL_CYC(PFULL), .PWR_POLL_CYC(PPOLL), .PROG_CYC(PROG), .SR_WR_CYC(40), .NVCR_WR_CYC(40),
            .SSE_CYC(60)) sfr_seq_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .serial_data_line0_i(dq0),
    .hold_data_line3_i(dq3), .supply_ok_i(supply_ok_i), .hw_reset_n_i(hw_reset_n_i),
    .nv_direct_read_i(nv_direct_read_i), .nv_proto_i(nv_proto_i), .ready_o(ready_o), .standby_o(standby_o),
    .deep_pd_o(), .wel_o(wel_o), .wip_o(wip_o), .pec_flag_o(pec_flag_o), .write_lock_o(write_lock_o),
    .lock_down_o(lock_down_o), .direct_read_mode_o(direct_read_mode_o), .proto_o(proto_o),
    .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code), .cmd_ignored_o(cmd_ignored_o));

  // Pulse counters and ready edge stamps
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rdy_q <= ready_o;
    if (cmd_valid_o === 1'b1)
      nvalid <= nvalid + 1;
    if (cmd_ignored_o === 1'b1)
      nign <= nign + 1;
    if (rdy_q === 1'b1 && ready_o === 1'b0)
      t_fall <= cyc;
    if (rdy_q === 1'b0 && ready_o === 1'b1)
      t_rise <= cyc;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send_cmd(input logic [7:0] code, input bit ok);
    sfr_host_model_i.frame(8, {code, 8'hff});
    if (ok)
      exp_valid++;
    else
      exp_ign++;
    check("accepted", nvalid, exp_valid);
    check("ignored", nign, exp_ign);
    check("code", cmd_code, code);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    stop_test();
  end

  initial begin
    void'($urandom(50));
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("ready_off", ready_o, 1'b0);
    check("pec_off", pec_flag_o, 1'b1);
    sfr_host_model_i.frame(8, 16'h06ff);
    check("frames_off", nvalid + nign, 0);
    $display("test supply_off done");
    @(negedge clk_i);
    supply_ok_i = 1'b1;
    t0 = cyc;
    op = 8'($urandom_range(254, 113));
    send_cmd(op, 1'b0);
    send_cmd(sfr_pkg::OP_RD_FLAG, 1'b1);
    send_cmd(sfr_pkg::OP_WR_EN, 1'b0);
    n = 0;
    while (ready_o !== 1'b1 && n < PFULL + 50) begin
      @(negedge clk_i);
      n++;
    end
    check("pwrup_time", (cyc - t0 >= PFULL) && (cyc - t0 <= PFULL + 8), 1'b1);
    check("standby", standby_o, 1'b1);
    check("wel", wel_o, 1'b0);
    check("wip", wip_o, 1'b0);
    check("locks", {write_lock_o, lock_down_o}, 2'h0);
    $display("test power_up done");
    send_cmd(sfr_pkg::OP_WR_EN, 1'b1);
    check("wel_set", wel_o, 1'b1);
    send_cmd(sfr_pkg::OP_PROG, 1'b1);
    for (int i = 0; i < 2; i++) begin
      check("pec_busy", pec_flag_o, 1'b0);
      check("wip_busy", wip_o, 1'b1);
      send_cmd(sfr_pkg::OP_RD_FLAG, 1'b1);
    end
    n = 0;
    while (pec_flag_o !== 1'b1 && n < PROG) begin
      @(negedge clk_i);
      n++;
    end
    check("pec_done", {pec_flag_o, wip_o, wel_o}, 3'h4);
    $display("test program done");
    send_cmd(sfr_pkg::OP_RST_EN, 1'b1);
    send_cmd(sfr_pkg::OP_RST_MEM, 1'b1);
    check("sw_rst_time", (t_rise > t_fall) && (t_rise - t_fall <= sfr_pkg::SW_FAST_CYC + 2), 1'b1);
    $display("test sw_reset done");
    @(negedge clk_i);
    nv_direct_read_i = 1'b1;
    nv_proto_i = 2'h2;
    hw_reset_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    hw_reset_n_i = 1'b1;
    t0 = cyc;
    repeat (30) @(negedge clk_i);
    check("hw_rst_time", (t_rise > t0) && (t_rise - t0 <= sfr_pkg::HW_FAST_CYC + 4), 1'b1);
    check("dr_reload", {direct_read_mode_o, proto_o}, 3'h6);
    $display("test hw_reset done");
    foreach (rec_q[i]) begin
      sfr_host_model_i.frame(rec_q[i], 16'hffff);
      check("dr_ended", direct_read_mode_o, 1'b0);
      check("proto_part1", proto_o, 2'h2);
    end
    sfr_host_model_i.frame(8, 16'hffff);
    check("proto_ext", proto_o, sfr_pkg::PROTO_EXT);
    check("dr_off", direct_read_mode_o, 1'b0);
    $display("test recovery done");
    stop_test();
  end
endmodule
`default_nettype wire
